// File: hw/engine_map.svh
`ifndef ENGINE_MAP_SVH
`define ENGINE_MAP_SVH
// Core clock rate and bit-time prescale values.
`define CLK_MHZ 100
`define BIT_CYC_100 4'h1
`define BIT_CYC_10 4'ha
// Address table.
`define TBL_LAST 11'h7ff
`define AGE_TIME_S 300
// Broadcast storm window and threshold bases in per mille.
`define STORM_WIN_MS 50
`define STORM_MAX_100 7490
`define STORM_MAX_10 749
`define PERMILLE 1000
`define RISE_PM_ALL100 100
`define RISE_PM_MIXED 10
`define FALL_PM_ALL100 50
`define FALL_PM_MIXED 5
// Buffer memory.
`define BLOCKS_TOTAL 9'h1c0
`define BLOCK_ROUND 12'h0ff
`define BLOCK_SHIFT 8
`define MAX_FRAME_BLOCKS 9'h006
// Frame legality in bytes.
`define MIN_FRAME 11'h040
`define MAX_UNTAGGED 11'h5ee
`define MAX_TAGGED 11'h5f2
`define PAUSE_DA 48'h0180c2000001
// Transmit timing in bit times.
`define IPG_BITS 7'h60
`define IPG_SHORT_BITS 7'h5c
`define SLOT_SHIFT 9
`define ATTEMPT_LIMIT 5'h10
`define BACKOFF_CAP 5'h09
// Register offsets.
`define REG_PORT0 8'h00
`define REG_PORT_LAST 8'h08
`define REG_GLOBAL 8'h0a
`define REG_VLAN0 8'h13
`define REG_VLAN_LAST 8'h22
`define REG_FREE 8'h30
`define REG_QDEPTH0 8'h31
`define REG_QDEPTH_LAST 8'h39
`define REG_STRAPS 8'h3a
// Field positions.
`define PC_LOCK 4
`define PC_RISE 5
`define PC_FALL 7
`define GC_AGING 0
`define GC_IPG92 1
`define GC_XOVER 2
// Reset values.
`define RST_VMAP 9'h1ff
`define RST_GCFG 3'h1
`define RST_LFSR 16'hace1
`endif

// File: hw/engine_pkg.sv
package engine_pkg;
  typedef enum logic [6:0] {
    S_CLR = 7'h01, S_IDLE = 7'h02, S_SRC = 7'h04, S_DSTREQ = 7'h08,
    S_DST = 7'h10, S_LEARN = 7'h20, S_SW = 7'h40
  } state_t;
  typedef struct packed {
    logic valid;
    logic age;
    logic lock;
    logic [3:0] port;
    logic [47:0] mac;
  } entry_t;
  typedef struct packed {
    state_t st;
    logic [3:0] port;
    logic [47:0] src;
    logic [47:0] dst;
    logic [10:0] len;
    logic ok, pause, bcast, mcast, src_hit, src_lockslot;
    logic [10:0] sweep;
    logic sweep_req;
    logic [35:0] age_cnt;
    logic [22:0] win_cnt;
    logic [8:0][12:0] bc_cnt;
    logic [8:0] storm;
    logic [8:0][8:0] pcfg;
    logic [15:0][8:0] vmap;
    logic [2:0] gcfg;
    logic [8:0] locked;
    logic [8:0][47:0] lock_mac;
    logic fwd_v;
    logic [8:0] fwd_mask;
    logic [8:0] blocks;
    logic [8:0][8:0] wr_ptr;
    logic [8:0][8:0] rd_ptr;
    logic [8:0][3:0] pre;
    logic [8:0][6:0] ipg;
    logic [8:0][24:0] hold;
    logic [8:0][4:0] att;
    logic [15:0] lfsr;
    logic [8:0] jam;
    logic [8:0] pause_tx;
    logic [8:0][1:0] mode;
    logic [8:0] xover;
    logic bp_s1, bp_s2, xo_s1, xo_s2;
    logic [8:0] sw_s1, sw_s2;
    logic [1:0] strap_cnt;
    logic bp_en;
    logic [15:0] rdata;
  } eng_t;
endpackage

// File: hw/switch_learn_forward_engine.sv
// Behaviour
// RULE1 - Autonegotiation prefers 100FD, 100HD, 10FD, 10HD.
// RULE2 - Whole frame checked; bad FCS never forwarded.
// RULE3 - Hashed table of 2K addresses with ports.
// RULE4 - New source learned only after good frame.
// RULE5 - Known source gets its age cleared.
// RULE6 - No learning when destination is pause address.
// RULE7 - Forward only within receiving port VLAN group.
// RULE8 - Known unicast to own port dropped.
// RULE9 - Unknown unicast and multicast flooded within group.
// RULE10 - Pause address dropped, other reserved ones forwarded.
// RULE11 - 300 second aging, switchable off.
// RULE12 - 448 blocks of 256 bytes, nine queues.
// RULE13 - Exponential backoff, counter reset after 16 tries.
// RULE14 - Gap of 96 bits, optionally 92.
// RULE15 - Drop runts, oversize and bad CRC.
// RULE16 - Jam half duplex port when buffer short.
// RULE17 - Back pressure enable strap caught at reset.
// RULE18 - Send pause when short; obey received pause.
// RULE19 - Discard broadcasts beyond rising threshold per 50ms.
// RULE20 - Rising threshold code decoding.
// RULE21 - Falling threshold code decoding.
// RULE22 - Port lock keeps first address, drops others.
// RULE23 - Sixteen VLAN groups chosen by port identifier.
// RULE24 - Received pause holds transmit for quanta.
// RULE25 - Auto crossover swaps pairs when enabled.
`timescale 1ns/1ns
`default_nettype none
`include "engine_map.svh"
module switch_learn_forward_engine import engine_pkg::*; #(
  parameter logic [35:0] AGE_CYC = 36'(64'(`AGE_TIME_S) * 64'(`CLK_MHZ)
    * 64'd1000000),
  parameter logic [22:0] STORM_CYC = 23'(`STORM_WIN_MS * `CLK_MHZ * 1000)
) (
  // Clock, reset and freeze.
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic enable_i,
  // Register port.
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // Received frame summary.
  input wire logic frm_valid_i,
  output logic frm_ready_o,
  input wire logic [3:0] frm_port_i,
  input wire logic [47:0] source_station_address_i,
  input wire logic [47:0] destination_station_address_i,
  input wire logic [10:0] frm_len_i,
  input wire logic frm_crc_ok_i,
  input wire logic frm_tagged_i,
  // Forwarding decision.
  output logic fwd_valid_o,
  output logic [8:0] fwd_mask_o,
  // Link modes.
  input wire logic [35:0] an_partner_i,
  output logic [17:0] link_mode_o,
  // Receive flow control.
  input wire logic [8:0] rx_start_i,
  output logic [8:0] jam_o,
  output logic [8:0] pause_tx_o,
  input wire logic pause_rx_i,
  input wire logic [3:0] pause_port_i,
  input wire logic [15:0] pause_quanta_i,
  // Transmit pacing and queues.
  input wire logic [8:0] col_i,
  input wire logic [8:0] tx_end_i,
  output logic [8:0] tx_allow_o,
  input wire logic blk_release_i,
  input wire logic [2:0] blk_count_i,
  // Straps and crossover.
  input wire logic backpressure_enable_strap_i,
  input wire logic auto_crossover_strap_i,
  input wire logic [8:0] pair_swap_i,
  output logic [8:0] auto_crossover_o
);
  localparam eng_t RST = '{st: S_CLR, vmap: {16{`RST_VMAP}},
    gcfg: `RST_GCFG, blocks: `BLOCKS_TOTAL, lfsr: `RST_LFSR, default: '0};
  eng_t q;
  eng_t n;
  tbl_if tbl ();
  entry_t rd;
  logic lockbad;
  logic learn_go;
  logic all100;

  // Index folding of a station address into the table.
  function automatic logic [10:0] hash(input logic [47:0] m);
    hash = m[10:0] ^ m[21:11] ^ m[32:22] ^ m[43:33] ^ {7'h0, m[47:44]};
  endfunction

  // Entry matches an address.
  function automatic logic hit(input entry_t e, input logic [47:0] m);
    hit = e.valid && (e.mac == m);
  endfunction

  // Blocks needed by a frame of a given length.
  function automatic logic [8:0] nblk(input logic [10:0] l);
    nblk = 9'((12'(l) + `BLOCK_ROUND) >> `BLOCK_SHIFT);
  endfunction

  // Mode from partner abilities: bit1 speed 100, bit0 full duplex.
  function automatic logic [1:0] an_pick(input logic [3:0] a);
    if (a[3]) an_pick = 2'h3;
    else if (a[2]) an_pick = 2'h2;
    else if (a[1]) an_pick = 2'h1;
    else an_pick = 2'h0;
  endfunction

  // Storm threshold; code 0 disables it, each step above code 1 doubles the base fraction.
  function automatic logic [12:0] thr(input logic [12:0] mx,
      input logic [1:0] code, input int pm);
    int t;
    t = (int'(mx) * pm * (1 << (code - 2'h1))) / `PERMILLE;
    thr = (code == 2'h0) ? 13'h0 : 13'(t);
  endfunction

  tbl_mem u_mem (
    .clock_i(clock_i),
    .enable_i(enable_i),
    .tbl(tbl)
  );
  assign rd = tbl.rdata;

  // Shared conditions for the decision and learning.
  assign lockbad = q.pcfg[q.port][`PC_LOCK] && q.locked[q.port]
    && (q.lock_mac[q.port] != q.src);
  // RULE4 RULE6 learn gating
  assign learn_go = !q.src_hit && q.ok && !q.pause && !q.src_lockslot
    && !lockbad;
  assign all100 = q.mode[0][1] & q.mode[1][1] & q.mode[2][1]
    & q.mode[3][1] & q.mode[4][1] & q.mode[5][1] & q.mode[6][1]
    & q.mode[7][1] & q.mode[8][1];

  // Table requests issued by the engine state.
  always_comb begin
    tbl.en = 1'b0;
    tbl.we = 1'b0;
    tbl.addr = hash(q.src);
    tbl.wdata = '0;
    case (q.st)
      S_CLR: begin
        tbl.en = 1'b1;
        tbl.we = 1'b1;
        tbl.addr = q.sweep;
      end
      S_IDLE: begin
        // RULE3 hashed lookup
        tbl.en = q.sweep_req || frm_valid_i;
        tbl.addr = q.sweep_req ? q.sweep : hash(source_station_address_i);
      end
      S_SRC: begin
        // RULE5 age refresh
        tbl.en = hit(rd, q.src);
        tbl.we = hit(rd, q.src);
        tbl.wdata = rd;
        tbl.wdata.age = 1'b0;
      end
      S_DSTREQ: begin
        tbl.en = 1'b1;
        tbl.addr = hash(q.dst);
      end
      S_LEARN: begin
        // RULE4 learn after end
        tbl.en = learn_go;
        tbl.we = learn_go;
        tbl.wdata = '{valid: 1'b1, age: 1'b0, port: q.port, mac: q.src,
          lock: q.pcfg[q.port][`PC_LOCK] && !q.locked[q.port]};
      end
      S_SW: begin
        // RULE11 remove stale
        tbl.en = rd.valid && !rd.lock && q.gcfg[`GC_AGING];
        tbl.we = tbl.en;
        tbl.addr = q.sweep;
        tbl.wdata = rd.age ? '0 : rd;
        tbl.wdata.age = !rd.age;
      end
      default: begin
        tbl.en = 1'b0;
      end
    endcase
  end

  // Next state of the whole engine.
  always_comb begin
    logic [8:0] base;
    logic [8:0] mask;
    logic [8:0] alloc;
    logic [12:0] cnt1;
    logic [12:0] rise;
    logic [12:0] fall;
    logic [12:0] mx;
    logic [4:0] att;
    logic [4:0] k;
    logic [8:0] r;
    logic win_end;
    base = '0;
    mask = '0;
    alloc = '0;
    cnt1 = '0;
    rise = '0;
    fall = '0;
    mx = '0;
    att = '0;
    k = '0;
    r = '0;
    win_end = 1'b0;
    n = q;
    n.fwd_v = 1'b0;
    n.jam = '0;
    n.pause_tx = '0;
    n.lfsr = {q.lfsr[14:0], q.lfsr[15] ^ q.lfsr[13] ^ q.lfsr[12]
      ^ q.lfsr[10]};
    // Pin synchronisers.
    n.bp_s1 = backpressure_enable_strap_i;
    n.bp_s2 = q.bp_s1;
    n.xo_s1 = auto_crossover_strap_i;
    n.xo_s2 = q.xo_s1;
    n.sw_s1 = pair_swap_i;
    n.sw_s2 = q.sw_s1;
    // RULE17 strap capture
    if (q.strap_cnt != 2'h3) begin
      n.strap_cnt = q.strap_cnt + 2'h1;
      if (q.strap_cnt == 2'h2) n.bp_en = q.bp_s2;
    end
    // RULE25 crossover swap
    n.xover = q.sw_s2 & {9{q.xo_s2 | q.gcfg[`GC_XOVER]}};
    // Register writes.
    if (reg_wr_i) begin
      if (reg_addr_i <= `REG_PORT_LAST)
        n.pcfg[4'(reg_addr_i)] = reg_wdata_i[8:0];
      if (reg_addr_i == `REG_GLOBAL) n.gcfg = reg_wdata_i[2:0];
      if (reg_addr_i >= `REG_VLAN0 && reg_addr_i <= `REG_VLAN_LAST)
        n.vmap[4'(reg_addr_i - `REG_VLAN0)] = reg_wdata_i[8:0];
    end
    // Per-port link mode, pacing and flow control.
    for (int p = 0; p < 9; p++) begin
      // RULE1 mode priority
      n.mode[p] = an_pick(an_partner_i[p*4 +: 4]);
      if (q.pre[p] == 4'h0)
        n.pre[p] = (q.mode[p][1] ? `BIT_CYC_100 : `BIT_CYC_10) - 4'h1;
      else
        n.pre[p] = q.pre[p] - 4'h1;
      // RULE14 gap reload
      if (tx_end_i[p])
        n.ipg[p] = q.gcfg[`GC_IPG92] ? `IPG_SHORT_BITS : `IPG_BITS;
      else if (q.pre[p] == 4'h0 && q.ipg[p] != 7'h0)
        n.ipg[p] = q.ipg[p] - 7'h1;
      if (q.pre[p] == 4'h0 && q.hold[p] != 25'h0)
        n.hold[p] = q.hold[p] - 25'h1;
      if (tx_end_i[p]) begin
        n.att[p] = 5'h0;
        n.rd_ptr[p] = q.rd_ptr[p] + 9'h1;
      end
      // RULE13 truncated backoff
      if (col_i[p] && !q.mode[p][0]) begin
        att = q.att[p] + 5'h1;
        k = (att > `BACKOFF_CAP) ? `BACKOFF_CAP : att;
        r = q.lfsr[8:0] & 9'((10'h1 << k) - 10'h1);
        n.att[p] = (att == `ATTEMPT_LIMIT) ? 5'h0 : att;
        n.hold[p] = (att == `ATTEMPT_LIMIT) ? 25'h0
          : 25'({r, 9'h0});
      end
      // RULE18 RULE24 pause hold
      if (pause_rx_i && pause_port_i == 4'(p))
        n.hold[p] = {pause_quanta_i, 9'h0};
      if (rx_start_i[p] && q.blocks < `MAX_FRAME_BLOCKS) begin
        // RULE18 send pause
        if (q.mode[p][0]) n.pause_tx[p] = 1'b1;
        // RULE16 jam collision
        else if (q.bp_en) n.jam[p] = 1'b1;
      end
    end
    // RULE11 aging timer
    if (q.gcfg[`GC_AGING]) begin
      n.age_cnt = q.age_cnt + 36'h1;
      if (q.age_cnt >= AGE_CYC - 36'h1) begin
        n.age_cnt = '0;
        n.sweep_req = 1'b1;
      end
    end
    // RULE19 RULE21 storm window
    win_end = (q.win_cnt >= STORM_CYC - 23'h1);
    n.win_cnt = win_end ? 23'h0 : q.win_cnt + 23'h1;
    if (win_end) begin
      for (int p = 0; p < 9; p++) begin
        mx = q.mode[p][1] ? 13'(`STORM_MAX_100) : 13'(`STORM_MAX_10);
        fall = thr(mx, q.pcfg[p][`PC_FALL +: 2],
          all100 ? `FALL_PM_ALL100 : `FALL_PM_MIXED);
        n.storm[p] = q.storm[p] && fall != 13'h0 && q.bc_cnt[p] >= fall;
        n.bc_cnt[p] = '0;
      end
    end
    case (q.st)
      S_CLR: begin
        n.sweep = q.sweep + 11'h1;
        if (q.sweep == `TBL_LAST) n.st = S_IDLE;
      end
      S_IDLE: begin
        if (q.sweep_req) begin
          n.st = S_SW;
        end else if (frm_valid_i) begin
          n.st = S_SRC;
          n.port = frm_port_i;
          n.src = source_station_address_i;
          n.dst = destination_station_address_i;
          n.len = frm_len_i;
          // RULE2 RULE15 legality
          n.ok = frm_crc_ok_i && frm_len_i >= `MIN_FRAME && frm_len_i
            <= (frm_tagged_i ? `MAX_TAGGED : `MAX_UNTAGGED);
          n.pause = destination_station_address_i == `PAUSE_DA;
          n.bcast = &destination_station_address_i;
          n.mcast = destination_station_address_i[40];
        end
      end
      S_SRC: begin
        n.src_hit = hit(rd, q.src);
        n.src_lockslot = rd.valid && rd.lock;
        n.st = S_DSTREQ;
      end
      S_DSTREQ: begin
        n.st = S_DST;
      end
      S_DST: begin
        // RULE7 RULE23 VLAN group
        base = q.vmap[q.pcfg[q.port][3:0]] & ~(9'h1 << q.port);
        mx = q.mode[q.port][1] ? 13'(`STORM_MAX_100)
          : 13'(`STORM_MAX_10);
        // RULE20 rising threshold
        rise = thr(mx, q.pcfg[q.port][`PC_RISE +: 2],
          all100 ? `RISE_PM_ALL100 : `RISE_PM_MIXED);
        cnt1 = (win_end ? 13'h0 : n.bc_cnt[q.port]) + 13'h1;
        if (q.bcast && q.ok) n.bc_cnt[q.port] = cnt1;
        // RULE19 storm discard
        if (q.bcast && rise != 13'h0 && (q.storm[q.port] || cnt1 > rise))
          n.storm[q.port] = 1'b1;
        if (hit(rd, q.dst) && !q.mcast)
          // RULE8 known unicast
          mask = (rd.port == q.port) ? 9'h0 : base & (9'h1 << rd.port);
        else
          // RULE9 flood group
          mask = base;
        // RULE2 RULE10 RULE22 drops
        if (!q.ok || q.pause || lockbad || n.storm[q.port]
            || q.blocks < nblk(q.len))
          mask = 9'h0;
        // RULE12 block and queue use
        if (mask != 9'h0) alloc = nblk(q.len);
        for (int p = 0; p < 9; p++)
          if (mask[p]) n.wr_ptr[p] = q.wr_ptr[p] + 9'h1;
        n.fwd_v = 1'b1;
        n.fwd_mask = mask;
        n.st = S_LEARN;
      end
      S_LEARN: begin
        // RULE22 lock first
        if (learn_go && q.pcfg[q.port][`PC_LOCK] && !q.locked[q.port]) begin
          n.locked[q.port] = 1'b1;
          n.lock_mac[q.port] = q.src;
        end
        n.st = S_IDLE;
      end
      S_SW: begin
        n.sweep = q.sweep + 11'h1;
        if (q.sweep == `TBL_LAST) n.sweep_req = 1'b0;
        n.st = S_IDLE;
      end
      default: begin
        n.st = S_IDLE;
      end
    endcase
    n.blocks = q.blocks - alloc
      + (blk_release_i ? 9'(blk_count_i) : 9'h0);
    // Register reads, shown only in the following cycle.
    n.rdata = '0;
    if (reg_rd_i) begin
      if (reg_addr_i <= `REG_PORT_LAST)
        n.rdata = {7'h0, q.pcfg[4'(reg_addr_i)]};
      if (reg_addr_i == `REG_GLOBAL) n.rdata = {13'h0, q.gcfg};
      if (reg_addr_i >= `REG_VLAN0 && reg_addr_i <= `REG_VLAN_LAST)
        n.rdata = {7'h0, q.vmap[4'(reg_addr_i - `REG_VLAN0)]};
      if (reg_addr_i == `REG_FREE) n.rdata = {7'h0, q.blocks};
      if (reg_addr_i >= `REG_QDEPTH0 && reg_addr_i <= `REG_QDEPTH_LAST)
        n.rdata = {7'h0, q.wr_ptr[4'(reg_addr_i - `REG_QDEPTH0)]
          - q.rd_ptr[4'(reg_addr_i - `REG_QDEPTH0)]};
      if (reg_addr_i == `REG_STRAPS) n.rdata = {15'h0, q.bp_en};
    end
  end

  // State register with clock enable.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= RST;
    end else if (enable_i) begin
      q <= n;
    end
  end

  // Outputs.
  assign reg_rdata_o = q.rdata;
  assign frm_ready_o = (q.st == S_IDLE) && !q.sweep_req;
  assign fwd_valid_o = q.fwd_v;
  assign fwd_mask_o = q.fwd_mask;
  assign link_mode_o = q.mode;
  assign jam_o = q.jam;
  assign pause_tx_o = q.pause_tx;
  assign auto_crossover_o = q.xover;
  always_comb begin
    for (int p = 0; p < 9; p++)
      tx_allow_o[p] = (q.hold[p] == 25'h0) && (q.ipg[p] == 7'h0);
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i || !enable_i);
  sequence s_decide;
    q.st == S_DST ##1 q.fwd_v;
  endsequence
  property p_bad_fcs;
    (q.st == S_DST && !q.ok) |-> s_decide ##0 q.fwd_mask == 9'h0;
  endproperty
  a_bad_fcs: assert property (p_bad_fcs) else $error("bad frame sent"); // RULE2
  property p_learn_good;
    (q.st == S_LEARN && tbl.we) |-> q.ok && !q.pause && !q.src_hit;
  endproperty
  a_learn_good: assert property (p_learn_good) else $error("bad learn"); // RULE4
  property p_refresh;
    (q.st == S_SRC && hit(rd, q.src)) |-> tbl.we && !tbl.wdata.age;
  endproperty
  a_refresh: assert property (p_refresh) else $error("age not cleared"); // RULE5
  property p_vlan;
    q.fwd_v |-> (q.fwd_mask & ~q.vmap[q.pcfg[q.port][3:0]]) == 9'h0;
  endproperty
  a_vlan: assert property (p_vlan) else $error("left VLAN group"); // RULE7
  property p_self;
    (q.st == S_DST && hit(rd, q.dst) && !q.mcast && rd.port == q.port)
      |-> s_decide ##0 q.fwd_mask == 9'h0;
  endproperty
  a_self: assert property (p_self) else $error("own port not dropped"); // RULE8
  property p_pause_drop;
    (q.st == S_DST && q.pause) |-> s_decide ##0 q.fwd_mask == 9'h0;
  endproperty
  a_pause_drop: assert property (p_pause_drop) else $error("pause sent"); // RULE10
  property p_gap;
    (tx_end_i[0] && q.mode[0][1] && !col_i[0])
      |=> !tx_allow_o[0] [*8];
  endproperty
  a_gap: assert property (p_gap) else $error("gap too short"); // RULE14
  property p_jam;
    (rx_start_i[1] && q.blocks < `MAX_FRAME_BLOCKS && !q.mode[1][0]
      && q.bp_en) |=> jam_o[1] && !pause_tx_o[1];
  endproperty
  a_jam: assert property (p_jam) else $error("no jam"); // RULE16
  property p_att_reset;
    (col_i[1] && !q.mode[1][0] && q.att[1] == 5'hf) |=> q.att[1] == 5'h0;
  endproperty
  a_att_reset: assert property (p_att_reset) else $error("no reset"); // RULE13
endmodule
`default_nettype wire

// File: hw/tbl_if.sv
`timescale 1ns/1ns
`default_nettype none
interface tbl_if;
  import engine_pkg::*;
  logic en;
  logic we;
  logic [10:0] addr;
  entry_t wdata;
  entry_t rdata;
  modport eng (output en, we, addr, wdata, input rdata);
  modport mem (input en, we, addr, wdata, output rdata);
endinterface
`default_nettype wire

// File: hw/tbl_mem.sv
`timescale 1ns/1ns
`default_nettype none
module tbl_mem import engine_pkg::*; (
  // Clock and freeze.
  input wire logic clock_i,
  input wire logic enable_i,
  // Table port.
  tbl_if.mem tbl
);
  entry_t mem [0:2047];
  entry_t rdata_ff;

  // Single port with registered read data; the engine clears it after reset.
  always_ff @(posedge clock_i) begin
    if (enable_i && tbl.en) begin
      if (tbl.we) begin
        mem[tbl.addr] <= tbl.wdata;
      end
      rdata_ff <= mem[tbl.addr];
    end
  end
  assign tbl.rdata = rdata_ff;
endmodule
`default_nettype wire

// File: sim/frame_source.sv
`timescale 1ns/1ns
`default_nettype none
module frame_source (
  // Clock and handshake.
  input wire logic clock_i,
  input wire logic ready_i,
  output logic valid_o,
  // Frame summary.
  output logic [3:0] port_o,
  output logic [47:0] src_o,
  output logic [47:0] dst_o,
  output logic [10:0] len_o,
  output logic crc_ok_o,
  output logic tagged_o
);
  // Nothing is offered until the first frame.
  initial begin
    valid_o = 1'b0;
    {port_o, src_o, dst_o, len_o, crc_ok_o, tagged_o} = '0;
  end

  // Offers one summary and holds it until the edge that takes it.
  task automatic send(input logic [3:0] p, input logic [47:0] sm, dm,
      input logic [10:0] len, input logic ok, tg, output logic taken);
    int n;
    n = 0;
    valid_o <= 1'b1;
    {port_o, src_o, dst_o, len_o, crc_ok_o, tagged_o} <= {p, sm, dm, len, ok, tg};
    #1;
    while (ready_i !== 1'b1 && n < 4000) begin
      n++;
      @(posedge clock_i);
      #1;
    end
    @(posedge clock_i);
    taken = (n < 4000);
    valid_o <= 1'b0;
    // Released address and length fields show the inverse so that stale data never looks valid.
    {src_o, dst_o, len_o} <= ~{sm, dm, len};
  endtask
endmodule
`default_nettype wire

// File: sim/switch_learn_forward_engine_test.sv
`timescale 1ns/1ns
`default_nettype none
module switch_learn_forward_engine_test;
  localparam logic [47:0] BC = 48'hffffffffffff;
  localparam logic [47:0] RSV = 48'h0180c2000000;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic pause_rx_i = 1'b0;
  logic blk_release_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic [15:0] pause_quanta_i = 16'h0000;
  logic [3:0] pause_port_i = 4'h0;
  logic [2:0] blk_count_i = 3'h0;
  logic [8:0] rx_start_i = 9'h000;
  logic [8:0] tx_end_i = 9'h000;
  logic [8:0] col_i = 9'h000;
  logic [8:0] pair_swap_i = 9'h000;
  logic [35:0] an_partner_i = 36'h58036124f;
  logic [15:0] reg_rdata_o;
  logic frm_valid_i, frm_ready_o, frm_crc_ok_i, frm_tagged_i, fwd_valid_o;
  logic [3:0] frm_port_i;
  logic [47:0] smac, dmac;
  logic [10:0] frm_len_i;
  logic [8:0] fwd_mask_o, jam_o, pause_tx_o, tx_allow_o, auto_crossover_o;
  logic [17:0] link_mode_o;
  int mismatches = 0;
  int n_compared = 0;

  // Free-running core clock.
  always #5 clock_i = ~clock_i;

  // Far-side frame source.
  frame_source src (.clock_i(clock_i), .ready_i(frm_ready_o),
    .valid_o(frm_valid_i), .port_o(frm_port_i), .src_o(smac), .dst_o(dmac),
    .len_o(frm_len_i), .crc_ok_o(frm_crc_ok_i), .tagged_o(frm_tagged_i));

  // Engine under test.
  switch_learn_forward_engine #(.AGE_CYC(36'h000001388),
    .STORM_CYC(23'h0000c8)) dut (.clock_i(clock_i), .nrst_i(nrst_i),
    .enable_i(1'b1), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .frm_valid_i(frm_valid_i), .frm_ready_o(frm_ready_o),
    .frm_port_i(frm_port_i), .source_station_address_i(smac),
    .destination_station_address_i(dmac), .frm_len_i(frm_len_i),
    .frm_crc_ok_i(frm_crc_ok_i), .frm_tagged_i(frm_tagged_i),
    .fwd_valid_o(fwd_valid_o), .fwd_mask_o(fwd_mask_o),
    .an_partner_i(an_partner_i), .link_mode_o(link_mode_o),
    .rx_start_i(rx_start_i), .jam_o(jam_o), .pause_tx_o(pause_tx_o),
    .pause_rx_i(pause_rx_i), .pause_port_i(pause_port_i),
    .pause_quanta_i(pause_quanta_i), .col_i(col_i), .tx_end_i(tx_end_i),
    .tx_allow_o(tx_allow_o), .blk_release_i(blk_release_i),
    .blk_count_i(blk_count_i), .backpressure_enable_strap_i(1'b1),
    .auto_crossover_strap_i(1'b0), .pair_swap_i(pair_swap_i),
    .auto_crossover_o(auto_crossover_o));

  task automatic chk(input string what, input logic [17:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    {reg_addr_i, reg_rd_i} <= {a, 1'b1};
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1;
    chk("reg", {2'h0, exp}, {2'h0, reg_rdata_o});
  endtask

  task automatic frame(input logic [3:0] p, input logic [47:0] s, d,
      input logic [10:0] len, input logic ok, tg, input logic [8:0] exp);
    logic tk;
    int n;
    src.send(p, s, d, len, ok, tg, tk);
    if (!tk) begin
      mismatches++;
      print_verdict();
    end
    n = 0;
    do begin
      @(posedge clock_i);
      #1;
      n++;
    end while (fwd_valid_o !== 1'b1 && n < 8);
    chk("fwd", {8'h00, 1'b1, exp}, {8'h00, fwd_valid_o, fwd_mask_o});
  endtask

  // Counts the cycles that port 0 is kept from transmitting.
  task automatic hold_len(input logic [17:0] exp);
    int n;
    n = 0;
    #1;
    while (tx_allow_o[0] !== 1'b1 && n < 2000) begin
      n++;
      @(posedge clock_i);
      #1;
    end
    chk("hold", exp, 18'(n));
  endtask

  task automatic t_regs();
    rchk(8'h30, 16'h01c0);
    wr(8'h30, 16'h0000);
    rchk(8'h30, 16'h01c0);
    rchk(8'h0a, 16'h0001);
    rchk(8'h22, 16'h01ff);
    rchk(8'h3f, 16'h0000);
    chk("mode", 18'h2c61b, link_mode_o);
  endtask

  task automatic t_learn();
    frame(4'h1, 48'h02_0000000001, BC, 11'h040, 1'b1, 1'b0, 9'h1fd);
    frame(4'h2, 48'h020000000002, 48'h020000000001, 11'h040, 1'b1, 1'b0,
      9'h002);
    frame(4'h1, 48'h020000000003, 48'h020000000001, 11'h040, 1'b1, 1'b0,
      9'h000);
    frame(4'h3, 48'h020000000004, BC, 11'h040, 1'b0, 1'b0, 9'h000);
    frame(4'h4, 48'h020000000005, 48'h020000000004, 11'h040, 1'b1, 1'b0,
      9'h1ef);
    frame(4'h3, 48'h020000000004, BC, 11'h03f, 1'b1, 1'b0, 9'h000);
    frame(4'h3, 48'h020000000004, BC, 11'h5ef, 1'b1, 1'b0, 9'h000);
    frame(4'h3, 48'h020000000004, BC, 11'h5f2, 1'b1, 1'b1, 9'h1f7);
  endtask

  task automatic t_reserved();
    frame(4'h0, 48'h020000000006, RSV | 48'h1, 11'h040, 1'b1, 1'b0,
      9'h000);
    frame(4'h5, 48'h020000000007, 48'h020000000006, 11'h040, 1'b1, 1'b0,
      9'h1df);
    frame(4'h0, 48'h020000000008, RSV, 11'h040, 1'b1, 1'b0, 9'h1fe);
    frame(4'h0, 48'h020000000008, RSV | 48'hf, 11'h040, 1'b1, 1'b0,
      9'h1fe);
  endtask

  task automatic t_vlan();
    wr(8'h05, 16'h0001);
    wr(8'h14, 16'h0021);
    frame(4'h5, 48'h020000000009, BC, 11'h040, 1'b1, 1'b0, 9'h001);
    frame(4'h5, 48'h020000000009, 48'h020000000001, 11'h040, 1'b1, 1'b0,
      9'h000);
    wr(8'h05, 16'h0000);
  endtask

  task automatic t_gap();
    tx_end_i <= 9'h001;
    @(posedge clock_i);
    tx_end_i <= 9'h000;
    hold_len(18'd96);
    wr(8'h0a, 16'h0003);
    tx_end_i <= 9'h001;
    @(posedge clock_i);
    tx_end_i <= 9'h000;
    hold_len(18'd92);
    wr(8'h0a, 16'h0001);
  endtask

  task automatic t_pause();
    {pause_rx_i, pause_port_i, pause_quanta_i} <= {1'b1, 4'h0, 16'h0001};
    @(posedge clock_i);
    pause_rx_i <= 1'b0;
    hold_len(18'd512);
  endtask

  task automatic release_blocks(input logic [2:0] n);
    {blk_release_i, blk_count_i} <= {1'b1, n};
    @(posedge clock_i);
    blk_release_i <= 1'b0;
    #1;
  endtask

  task automatic t_fill();
    release_blocks(3'h6);
    release_blocks(3'h7);
    rchk(8'h30, 16'h01c0);
    for (int i = 0; i < 74; i++) begin
      frame(4'h2, 48'h02000000000a, BC, 11'h5ee, 1'b1, 1'b0, 9'h1fb);
    end
    rchk(8'h30, 16'h0004);
    frame(4'h2, 48'h02000000000a, BC, 11'h5ee, 1'b1, 1'b0, 9'h000);
    rx_start_i <= 9'h003;
    @(posedge clock_i);
    rx_start_i <= 9'h000;
    #1;
    chk("flow", 18'h00202, {pause_tx_o, jam_o});
    rchk(8'h3a, 16'h0001);
    release_blocks(3'h6);
    rchk(8'h30, 16'h000a);
  endtask

  // Sixteen collisions on half-duplex port 1, then crossover gating.
  task automatic t_pins();
    col_i <= 9'h002;
    pair_swap_i <= 9'h0a5;
    repeat (16) @(posedge clock_i);
    col_i <= 9'h000;
    #1;
    chk("backoff", 18'h00001, 18'(tx_allow_o[1]));
    chk("xover", 18'h00000, 18'(auto_crossover_o));
    wr(8'h0a, 16'h0005);
    @(posedge clock_i);
    #1;
    chk("xover", 18'h000a5, 18'(auto_crossover_o));
    wr(8'h0a, 16'h0001);
  endtask

  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Cuts a hung run short.
  initial begin
    repeat (100000) @(posedge clock_i);
    mismatches++;
    print_verdict();
  end

  // Main sequence.
  initial begin
    repeat (4) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(posedge clock_i);
    t_regs();
    t_learn();
    t_reserved();
    t_vlan();
    t_gap();
    t_pause();
    t_fill();
    t_pins();
    print_verdict();
  end
endmodule
`default_nettype wire
